// ### hw/fpg_consts.vh
// Behaviour
// - Programming only clears bits; erase sets them
// - Hardware times operations, stalls execution meanwhile
// - Operation with supply monitor off resets device
// - Key codes A5 then F1, any spacing
// - Bad key or early operation blocks until reset
// - Lock returns after every completed operation
// - Write-enable steers external writes to flash
// - Erase clears whole 512-byte page to FF
// - Write-enable needed; erase also needs erase-enable
// - Write inside page with both enables erases it
// - Block select: zero byte, one two-byte block
// - Block program lasts as long as byte
// - Byte mode programs after every flash write
// - Block programs after odd write, even first
// - Top 1024 bytes reserved, never accessible
// - Security byte complement locks pages from zero
// - Security byte page locked when any locked
// - External reads go to data RAM except while busy
// - Reserved or forbidden locked access resets device
// - Security page never erased, security byte fixed
`ifndef FPG_CONSTS_VH
`define FPG_CONSTS_VH
`define FPG_KEY_FIRST      8'hA5
`define FPG_KEY_SECOND     8'hF1
`define FPG_ERASED_BYTE    8'hFF
`define FPG_ADR_KEY        8'h00
`define FPG_ADR_CTRL       8'h04
`define FPG_ADR_PREFETCH   8'h08
`define FPG_ADR_STATUS     8'h0C
`define FPG_CTRL_WE_BIT    0
`define FPG_CTRL_EE_BIT    1
`define FPG_PF_BWS_BIT     0
`define FPG_PAGE_LSB       9
`define FPG_RSVD_BASE      16'hFC00
`define FPG_LOCKPG_LARGE   16'hFA00
`define FPG_LOCKPG_SMALL   16'h7E00
`define FPG_LOCKBYTE_LARGE 16'hFBFF
`define FPG_LOCKBYTE_SMALL 16'h7FFF
`define FPG_CLK_PERIOD_NS  8
`define FPG_WRITE_TIME_NS  40000
`define FPG_ERASE_TIME_NS  10000000
`define FPG_PROG_CYCLES    ((`FPG_WRITE_TIME_NS + `FPG_CLK_PERIOD_NS - 1) / `FPG_CLK_PERIOD_NS)
`define FPG_ERASE_CYCLES   ((`FPG_ERASE_TIME_NS + `FPG_CLK_PERIOD_NS - 1) / `FPG_CLK_PERIOD_NS)
`define FPG_KS_LOCKED      2'b00
`define FPG_KS_HALF        2'b01
`define FPG_KS_OPEN        2'b10
`define FPG_KS_DISABLED    2'b11
`endif

// ### hw/fpg_flash_guard.v
`timescale 1ns/10ps
`include "fpg_consts.vh"
module fpg_flash_guard #(
  parameter        LARGE_ARRAY  = 1,
  parameter [23:0] PROG_CYCLES  = `FPG_PROG_CYCLES,
  parameter [23:0] ERASE_CYCLES = `FPG_ERASE_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        xw_stb_i,
  input  wire [15:0] xw_addr_i,
  input  wire [7:0]  xw_data_i,
  input  wire        xr_stb_i,
  input  wire [15:0] xr_addr_i,
  input  wire        cr_stb_i,
  input  wire [15:0] cr_addr_i,
  input  wire        exec_locked_i,
  input  wire        vdd_mon_en_i,
  input  wire [7:0]  lock_byte_i,
  input  wire [15:0] fl_word_i,
  output reg         stall_o,
  output reg         ram_we_o,
  output reg         ram_re_o,
  output reg  [15:0] ram_addr_o,
  output reg  [7:0]  ram_wdata_o,
  output reg         fl_prog_o,
  output reg         fl_erase_o,
  output reg  [15:0] fl_addr_o,
  output reg  [15:0] fl_wdata_o,
  output reg  [1:0]  fl_ben_o,
  output reg         flash_err_rst_o
);
  reg        store_write_enable_reg;
  reg        store_erase_enable_reg;
  reg        block_write_select_reg;
  reg        busy_reg;
  reg [23:0] timer_reg;
  reg        even_pend_reg;
  reg [15:0] even_addr_reg;
  reg [7:0]  even_data_reg;

  wire       key_open;
  wire       key_disabled;
  wire [1:0] key_state;
  wire       w_reserved;
  wire       w_lock_page;
  wire       w_lock_byte;
  wire       w_deny;
  wire       r_lock_byte;
  wire       r_deny;
  wire       wb_req;
  wire       wb_wr;
  wire       key_wr;
  wire       flash_wr;
  wire       try_op;
  wire       bad_addr;
  wire       go_ok;
  wire       go_erase;
  wire       go_even;
  wire       go_prog;
  wire       op_done;
  wire       attempt;
  wire       consume;
  wire [7:0] old_even;
  wire [7:0] old_odd;
  wire [7:0] new_even;
  wire [7:0] new_odd;
  wire [1:0] ben;

  function [7:0] clear_only;
    input [7:0] old_val;
    input [7:0] new_val;
    begin
      clear_only = old_val & new_val;
    end
  endfunction

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes take effect at the edge where the master samples ack
  assign wb_wr    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign key_wr   = wb_wr && (wb_adr_i == `FPG_ADR_KEY);
  assign flash_wr = xw_stb_i && !busy_reg && store_write_enable_reg;
  assign try_op   = flash_wr && vdd_mon_en_i && !key_disabled;
  assign attempt  = flash_wr && vdd_mon_en_i && !key_open;
  assign bad_addr = w_deny || w_lock_byte ||
                    (store_erase_enable_reg && (w_lock_page || w_reserved));
  assign go_ok    = try_op && key_open && !bad_addr;
  assign go_erase = go_ok && store_erase_enable_reg;
  assign go_even  = go_ok && !store_erase_enable_reg && block_write_select_reg &&
                    !xw_addr_i[0];
  assign go_prog  = go_ok && !store_erase_enable_reg && !go_even;
  assign op_done  = busy_reg && (timer_reg == 24'h000001);
  assign consume  = op_done || go_even;

  fpg_key_lock u_key (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .key_wr_i   (key_wr),
    .key_data_i (wb_dat_i[7:0]),
    .attempt_i  (attempt),
    .consume_i  (consume),
    .open_o     (key_open),
    .disabled_o (key_disabled),
    .state_o    (key_state)
  );

  fpg_page_guard u_wguard (
    .addr_i        (xw_addr_i),
    .lock_byte_i   (lock_byte_i),
    .large_i       (LARGE_ARRAY != 0),
    .exec_locked_i (exec_locked_i),
    .reserved_o    (w_reserved),
    .lock_page_o   (w_lock_page),
    .lock_byte_o   (w_lock_byte),
    .deny_o        (w_deny)
  );

  fpg_page_guard u_rguard (
    .addr_i        (cr_addr_i),
    .lock_byte_i   (lock_byte_i),
    .large_i       (LARGE_ARRAY != 0),
    .exec_locked_i (exec_locked_i),
    .reserved_o    (),
    .lock_page_o   (),
    .lock_byte_o   (r_lock_byte),
    .deny_o        (r_deny)
  );

  // Block data: pending even byte, odd byte, unwritten byte left as erased
  assign old_even = fl_word_i[7:0];
  assign old_odd  = fl_word_i[15:8];
  assign new_even = !block_write_select_reg ? xw_data_i :
                    (even_pend_reg && (even_addr_reg[15:1] == xw_addr_i[15:1])) ?
                    even_data_reg : `FPG_ERASED_BYTE;
  assign new_odd  = xw_data_i;
  assign ben      = !block_write_select_reg ? (xw_addr_i[0] ? 2'b10 : 2'b01) :
                    2'b11;

  // Register bus slave, one wait state, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o               <= 1'b0;
      wb_dat_o               <= 32'h00000000;
      store_write_enable_reg <= 1'b0;
      store_erase_enable_reg <= 1'b0;
      block_write_select_reg <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `FPG_ADR_KEY:      wb_dat_o <= {30'h00000000, key_state};
          `FPG_ADR_CTRL:     wb_dat_o <= {30'h00000000, store_erase_enable_reg,
                                          store_write_enable_reg};
          `FPG_ADR_PREFETCH: wb_dat_o <= {31'h00000000, block_write_select_reg};
          `FPG_ADR_STATUS:   wb_dat_o <= {28'h0000000, even_pend_reg, key_disabled,
                                          key_open, busy_reg};
          default:           wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wb_wr && (wb_adr_i == `FPG_ADR_CTRL)) begin
        store_write_enable_reg <= wb_dat_i[`FPG_CTRL_WE_BIT];
        store_erase_enable_reg <= wb_dat_i[`FPG_CTRL_EE_BIT];
      end
      if (wb_wr && (wb_adr_i == `FPG_ADR_PREFETCH))
        block_write_select_reg <= wb_dat_i[`FPG_PF_BWS_BIT];
    end
  end

  // Operation timer and stall
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg   <= 1'b0;
      timer_reg  <= 24'h000000;
      stall_o    <= 1'b0;
      fl_prog_o  <= 1'b0;
      fl_erase_o <= 1'b0;
      fl_addr_o  <= 16'h0000;
      fl_wdata_o <= 16'h0000;
      fl_ben_o   <= 2'b00;
    end else begin
      fl_prog_o  <= 1'b0;
      fl_erase_o <= 1'b0;
      if (go_erase) begin
        busy_reg   <= 1'b1;
        stall_o    <= 1'b1;
        timer_reg  <= ERASE_CYCLES;
        fl_erase_o <= 1'b1;
        fl_addr_o  <= {xw_addr_i[15:`FPG_PAGE_LSB], 9'h000};
        fl_wdata_o <= {`FPG_ERASED_BYTE, `FPG_ERASED_BYTE};
        fl_ben_o   <= 2'b11;
      end else if (go_prog) begin
        busy_reg   <= 1'b1;
        stall_o    <= 1'b1;
        timer_reg  <= PROG_CYCLES;
        fl_prog_o  <= 1'b1;
        fl_addr_o  <= {xw_addr_i[15:1], 1'b0};
        fl_wdata_o <= {clear_only(old_odd, new_odd), clear_only(old_even, new_even)};
        fl_ben_o   <= ben;
      end else if (op_done) begin
        busy_reg  <= 1'b0;
        stall_o   <= 1'b0;
        timer_reg <= 24'h000000;
      end else if (busy_reg) begin
        timer_reg <= timer_reg - 24'h000001;
      end
    end
  end

  // Even byte of a block waits for its odd partner
  always @(posedge clk_i) begin
    if (rst_i) begin
      even_pend_reg <= 1'b0;
      even_addr_reg <= 16'h0000;
      even_data_reg <= 8'h00;
    end else if (go_even) begin
      even_pend_reg <= 1'b1;
      even_addr_reg <= xw_addr_i;
      even_data_reg <= xw_data_i;
    end else if (go_prog || !block_write_select_reg) begin
      even_pend_reg <= 1'b0;
    end
  end

  // Data RAM path and error reset requests
  always @(posedge clk_i) begin
    if (rst_i) begin
      ram_we_o        <= 1'b0;
      ram_re_o        <= 1'b0;
      ram_addr_o      <= 16'h0000;
      ram_wdata_o     <= 8'h00;
      flash_err_rst_o <= 1'b0;
    end else begin
      ram_we_o    <= xw_stb_i && !busy_reg && !store_write_enable_reg;
      ram_re_o    <= xr_stb_i && !busy_reg;
      ram_wdata_o <= xw_data_i;
      if (xr_stb_i)
        ram_addr_o <= xr_addr_i;
      else
        ram_addr_o <= xw_addr_i;
      flash_err_rst_o <= (flash_wr && !vdd_mon_en_i) ||
                         (try_op && key_open && bad_addr) ||
                         (cr_stb_i && !busy_reg && r_deny && !r_lock_byte);
    end
  end
endmodule // fpg_flash_guard

// ### hw/fpg_key_lock.v
`timescale 1ns/10ps
`include "fpg_consts.vh"
module fpg_key_lock (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       key_wr_i,
  input  wire [7:0] key_data_i,
  input  wire       attempt_i,
  input  wire       consume_i,
  output wire       open_o,
  output wire       disabled_o,
  output wire [1:0] state_o
);
  reg [1:0] state_reg;
  reg [1:0] state_next;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `FPG_KS_LOCKED: begin
        if (attempt_i)
          state_next = `FPG_KS_DISABLED;
        else if (key_wr_i)
          state_next = (key_data_i == `FPG_KEY_FIRST) ? `FPG_KS_HALF : `FPG_KS_DISABLED;
      end
      `FPG_KS_HALF: begin
        if (attempt_i)
          state_next = `FPG_KS_DISABLED;
        else if (key_wr_i)
          state_next = (key_data_i == `FPG_KEY_SECOND) ? `FPG_KS_OPEN : `FPG_KS_DISABLED;
      end
      `FPG_KS_OPEN: begin
        if (key_wr_i)
          state_next = `FPG_KS_DISABLED;
        else if (consume_i)
          state_next = `FPG_KS_LOCKED;
      end
      `FPG_KS_DISABLED: state_next = `FPG_KS_DISABLED;
      default: state_next = `FPG_KS_LOCKED;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i)
      state_reg <= `FPG_KS_LOCKED;
    else
      state_reg <= state_next;
  end

  assign open_o     = (state_reg == `FPG_KS_OPEN);
  assign disabled_o = (state_reg == `FPG_KS_DISABLED);
  assign state_o    = state_reg;
endmodule // fpg_key_lock

// ### hw/fpg_page_guard.v
`timescale 1ns/10ps
`include "fpg_consts.vh"
module fpg_page_guard (
  input  wire [15:0] addr_i,
  input  wire [7:0]  lock_byte_i,
  input  wire        large_i,
  input  wire        exec_locked_i,
  output wire        reserved_o,
  output wire        lock_page_o,
  output wire        lock_byte_o,
  output wire        deny_o
);
  wire [7:0]  pages_locked;
  wire [7:0]  page_num;
  wire [15:0] lock_page_base;
  wire        page_locked;

  assign pages_locked   = ~lock_byte_i;
  assign page_num       = {1'b0, addr_i[15:`FPG_PAGE_LSB]};
  assign lock_page_base = large_i ? `FPG_LOCKPG_LARGE : `FPG_LOCKPG_SMALL;
  assign reserved_o     = (addr_i >= `FPG_RSVD_BASE);
  assign lock_page_o    = (addr_i[15:`FPG_PAGE_LSB] == lock_page_base[15:`FPG_PAGE_LSB]);
  assign lock_byte_o    = (addr_i == (large_i ? `FPG_LOCKBYTE_LARGE : `FPG_LOCKBYTE_SMALL));
  assign page_locked    = (page_num < pages_locked) ||
                          (lock_page_o && (pages_locked != 8'h00));
  assign deny_o         = reserved_o || (page_locked && !exec_locked_i);
endmodule // fpg_page_guard

// ### verification/fpg_flash_model.sv
`timescale 1ns/10ps
module fpg_flash_model (
  input  wire        clk_i, prog_i, erase_i,
  input  wire [15:0] addr_i, wdata_i, rd_addr_i,
  input  wire [1:0]  ben_i,
  output wire [15:0] word_o
);
  reg [7:0] mem [0:65535];
  integer   i;
  initial for (i = 0; i < 65536; i = i + 1) mem[i] = 8'hFF;
  assign word_o = {mem[{rd_addr_i[15:1], 1'b1}], mem[{rd_addr_i[15:1], 1'b0}]};
  // Cells only lose ones when programmed; erase refills a page
  always @(posedge clk_i) begin
    if (prog_i && ben_i[0]) mem[addr_i] <= mem[addr_i] & wdata_i[7:0];
    if (prog_i && ben_i[1])
      mem[addr_i | 16'h0001] <= mem[addr_i | 16'h0001] & wdata_i[15:8];
    if (erase_i) for (i = 0; i < 512; i = i + 1) mem[{addr_i[15:9], i[8:0]}] <= 8'hFF;
  end
endmodule // fpg_flash_model

// ### verification/fpg_guard_props.sv
`timescale 1ns/10ps
module fpg_guard_props #(
  parameter        LARGE_ARRAY  = 1,
  parameter [23:0] PROG_CYCLES  = 24'h000008,
  parameter [23:0] ERASE_CYCLES = 24'h000014
) (
  input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, xw_stb_i, xr_stb_i,
  input wire        vdd_mon_en_i, stall_o, ram_re_o, fl_prog_o, fl_erase_o, flash_err_rst_o,
  input wire [15:0] xr_addr_i, fl_word_i, ram_addr_o, fl_addr_o, fl_wdata_o,
  input wire [1:0]  fl_ben_o
);
  localparam [6:0] LOCK_PG = LARGE_ARRAY ? 7'h7D : 7'h3F;
  reg [23:0] st_cnt;
  reg        was_er;
  // Busy length and kind of the running operation
  always @(posedge clk_i) begin
    st_cnt <= (rst_i || !stall_o) ? 24'h000000 : st_cnt + 24'h000001;
    if (rst_i || fl_prog_o) was_er <= 1'b0;
    else if (fl_erase_o) was_er <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer not a single pulse");
  a_err_single: assert property (flash_err_rst_o |=> !flash_err_rst_o)
    else $error("Error request longer than one cycle");
  a_stall_count: assert property ($fell(stall_o) |->
    st_cnt == (was_er ? ERASE_CYCLES : PROG_CYCLES)) else $error("Busy time wrong");
  a_mon_off: assert property (
    xw_stb_i && !stall_o && !vdd_mon_en_i |=> !fl_prog_o && !fl_erase_o)
    else $error("Operation with monitor off");
  a_read_ram: assert property (
    xr_stb_i |=> ram_re_o && ram_addr_o == $past(xr_addr_i)) else $error("Read not to RAM");
  a_no_ones: assert property (fl_prog_o |-> (fl_wdata_o & ~$past(fl_word_i) &
    {{8{fl_ben_o[1]}}, {8{fl_ben_o[0]}}}) == 16'h0000) else $error("Program sets a bit");
  a_erase_page: assert property (fl_erase_o |->
    fl_addr_o[8:0] == 9'h000 && fl_addr_o[15:9] != LOCK_PG) else $error("Bad erase page");
  a_op_stalls: assert property (
    fl_prog_o || fl_erase_o |-> stall_o && !fl_addr_o[0]) else $error("Op without stall");
endmodule // fpg_guard_props
bind fpg_flash_guard fpg_guard_props #(.LARGE_ARRAY(LARGE_ARRAY), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .xw_stb_i, .xr_stb_i, .vdd_mon_en_i, .stall_o, .ram_re_o, .fl_prog_o, .fl_erase_o,
  .flash_err_rst_o, .xr_addr_i, .fl_word_i, .ram_addr_o, .fl_addr_o, .fl_wdata_o, .fl_ben_o);

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam PC = 8;
  localparam EC = 20;
  reg         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg         xw_stb_i = 1'b0, xr_stb_i = 1'b0, vdd_mon_en_i = 1'b1, got_err;
  reg         cr_stb_i = 1'b0, exec_locked_i = 1'b0;
  reg  [7:0]  wb_adr_i = 8'h00, xw_data_i = 8'h00, lock_byte_i = 8'hFF;
  reg  [15:0] xw_addr_i = 16'h0000, xr_addr_i = 16'h0000, cr_addr_i = 16'h0000;
  reg  [31:0] wb_dat_i = 32'h00000000, rq;
  reg  [24:0] got_ram;
  wire [31:0] wb_dat_o;
  wire [15:0] fl_word_i, fl_addr_o, fl_wdata_o, ram_addr_o;
  wire [7:0]  ram_wdata_o;
  wire [1:0]  fl_ben_o;
  wire        wb_ack_o, stall_o, ram_we_o, ram_re_o, fl_prog_o, fl_erase_o, flash_err_rst_o;
  integer     n_st, n_fail = 0, comparisons = 0;
  always #4 clk_i = ~clk_i;
  fpg_flash_guard #(.LARGE_ARRAY(1), .PROG_CYCLES(24'h000008), .ERASE_CYCLES(24'h000014))
    u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .xw_stb_i, .xw_addr_i, .xw_data_i, .xr_stb_i,
    .xr_addr_i, .cr_stb_i, .cr_addr_i, .exec_locked_i, .vdd_mon_en_i,
    .lock_byte_i, .fl_word_i, .stall_o, .ram_we_o, .ram_re_o, .ram_addr_o, .ram_wdata_o,
    .fl_prog_o, .fl_erase_o, .fl_addr_o, .fl_wdata_o, .fl_ben_o, .flash_err_rst_o);
  fpg_flash_model u_flash (.clk_i, .prog_i(fl_prog_o), .erase_i(fl_erase_o),
    .addr_i(fl_addr_o), .wdata_i(fl_wdata_o), .rd_addr_i(xw_addr_i), .ben_i(fl_ben_o),
    .word_o(fl_word_i));
  task end_sim;
    begin
      $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      for (k = 0; k < 50 && wb_ack_o !== 1'b1; k = k + 1) @(posedge clk_i);
      rq = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h00000000);
      chk(rq, e);
    end
  endtask
  task key;
    begin
      wb(1'b1, 8'h00, 32'h000000A5);
      wb(1'b1, 8'h00, 32'h000000F1);
    end
  endtask
  task xw(input [15:0] a, input [7:0] d);
    begin
      xw_stb_i <= 1'b1;
      xw_addr_i <= a;
      xw_data_i <= d;
      @(posedge clk_i);
      xw_stb_i <= 1'b0;
      @(posedge clk_i);
      got_err = flash_err_rst_o;
      got_ram = {ram_we_o, ram_addr_o, ram_wdata_o};
      for (n_st = 0; n_st < 99 && stall_o === 1'b1; n_st = n_st + 1) @(posedge clk_i);
    end
  endtask
  task cr(input [15:0] a);
    begin
      cr_stb_i <= 1'b1;
      cr_addr_i <= a;
      @(posedge clk_i);
      cr_stb_i <= 1'b0;
      @(posedge clk_i);
      got_err = flash_err_rst_o;
    end
  endtask
  task rs;
    begin
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail = n_fail + 1;
    end_sim;
  end
  initial begin
    rs;
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h08, 0);
    rd(8'h10, 0);
    wb(1'b1, 8'h00, 32'h000000A5);
    rd(8'h00, 1);
    wb(1'b1, 8'h00, 32'h000000F1);
    rd(8'h00, 2);
    wb(1'b1, 8'h04, 32'h00000001);
    xw(16'h1000, 8'h5A);
    chk(n_st, PC);
    chk(u_flash.mem[16'h1000], 8'h5A);
    rd(8'h00, 0);
    key;
    xw(16'h1000, 8'hA5);
    chk(u_flash.mem[16'h1000], 8'h00);
    wb(1'b1, 8'h08, 32'h00000001);
    key;
    xw(16'h1100, 8'h12);
    chk(n_st, 0);
    rd(8'h0C, 32'h00000008);
    key;
    xw(16'h1101, 8'h34);
    chk(n_st, PC);
    chk({u_flash.mem[16'h1101], u_flash.mem[16'h1100]}, 16'h3412);
    key;
    xw(16'h1100, 8'hFF);
    key;
    xw(16'h1101, 8'h30);
    chk({u_flash.mem[16'h1101], u_flash.mem[16'h1100]}, 16'h3012);
    wb(1'b1, 8'h08, 32'h00000000);
    key;
    wb(1'b1, 8'h04, 32'h00000003);
    xw(16'h11F3, 8'h00);
    chk(n_st, EC);
    chk({u_flash.mem[16'h1000], u_flash.mem[16'h1101]}, 16'hFFFF);
    wb(1'b1, 8'h04, 32'h00000000);
    xw(16'h2000, 8'h77);
    chk(got_ram, {1'b1, 16'h2000, 8'h77});
    wb(1'b1, 8'h04, 32'h00000001);
    xr_stb_i <= 1'b1;
    xr_addr_i <= 16'h3000;
    @(posedge clk_i);
    xr_stb_i <= 1'b0;
    @(posedge clk_i);
    chk({ram_re_o, ram_addr_o, fl_prog_o}, {1'b1, 16'h3000, 1'b0});
    key;
    xw(16'hFC10, 8'h00);
    chk(got_err, 1);
    rs;
    wb(1'b1, 8'h04, 32'h00000001);
    vdd_mon_en_i <= 1'b0;
    key;
    xw(16'h1200, 8'h00);
    chk({got_err, n_st[7:0]}, 9'h100);
    vdd_mon_en_i <= 1'b1;
    rs;
    lock_byte_i <= 8'hFD;
    wb(1'b1, 8'h04, 32'h00000001);
    key;
    xw(16'h0400, 8'h00);
    chk(n_st, PC);
    key;
    xw(16'h03FF, 8'h00);
    chk(got_err, 1);
    rs;
    wb(1'b1, 8'h04, 32'h00000001);
    key;
    xw(16'hFA10, 8'h00);
    chk(got_err, 1);
    rs;
    cr(16'h0100);
    chk(got_err, 1);
    cr(16'hFBFF);
    chk(got_err, 0);
    exec_locked_i <= 1'b1;
    wb(1'b1, 8'h04, 32'h00000001);
    key;
    xw(16'h0200, 8'h00);
    chk({got_err, n_st[7:0]}, {1'b0, PC[7:0]});
    exec_locked_i <= 1'b0;
    lock_byte_i <= 8'hFF;
    wb(1'b1, 8'h04, 32'h00000003);
    key;
    xw(16'hFA00, 8'h00);
    chk(got_err, 1);
    rs;
    wb(1'b1, 8'h04, 32'h00000001);
    xw(16'h1300, 8'h00);
    chk(n_st, 0);
    key;
    rd(8'h00, 3);
    rs;
    rd(8'h00, 0);
    end_sim;
  end
endmodule // testbench
